// ### tio_pkg.sv
// Constants, field layouts and carrier types of the timed I/O port
package tio_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] TIO_OFF_CTRL = 12'h000;
  localparam logic [11:0] TIO_OFF_DATA = 12'h004;
  localparam logic [11:0] TIO_OFF_COND = 12'h008;
  localparam logic [11:0] TIO_OFF_TIME = 12'h00C;
  localparam logic [11:0] TIO_OFF_COUNT = 12'h010;
  localparam logic [11:0] TIO_OFF_TSTAMP = 12'h014;
  localparam logic [11:0] TIO_OFF_STATUS = 12'h018;
  localparam logic [11:0] TIO_OFF_NARROW = 12'h01C;
  localparam logic [11:0] TIO_OFF_CB0 = 12'h020;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int TIO_NCB = 6;
  localparam int TIO_CTRL_W = 14;
  localparam logic [2:0] TIO_CB_RESET = 3'h0;
  localparam logic [15:0] TIO_DIV_RESET = 16'h0000;
  localparam logic [31:0] TIO_LINK_MASK = 32'h000003FE;
  localparam int TIO_REF_MHZ = 100;

  // Width codes
  localparam logic [2:0] TIO_W1 = 3'h0;
  localparam logic [2:0] TIO_W4 = 3'h1;
  localparam logic [2:0] TIO_W8 = 3'h2;
  localparam logic [2:0] TIO_W16 = 3'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic narrow_en;
    logic link_en;
    logic strobe_en;
    logic timed_en;
    logic cond_ne;
    logic cond_en;
    logic [2:0] clk_sel;
    logic [2:0] width;
    logic dir_out;
    logic enable;
  } tio_ctrl_type;

  typedef struct packed {
    logic [15:0] div;
    logic ext_src;
  } tio_cb_type;

  typedef enum logic [1:0] {
    TIO_ST_IDLE = 2'b00,
    TIO_ST_WAIT = 2'b01,
    TIO_ST_SHIFT = 2'b10
  } tio_state_type;

endpackage

// ### tio_port.sv
// Timed I/O port with clock blocks, serializer and APB register file
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - Port width 1, 4, 8, 16 or 32 bits, all pins one direction.
// - Port drives pins high or low, or samples them, optionally on a condition.
// - Each register access completes in two cycles: setup, then access with pready.
// - Data passes through a shift register and a transfer register.
// - A 16-bit counter times moves between pins and transfer register.
// - Counter readable any time; transfer may wait for a programmed count.
// - Every transfer stores the counter as a readable timestamp.
// - An enabled link disables port drive on its shared pins; input sampling still reads them.
// - Narrow port wins shared pins; unshared wide pins stay usable.
// - A port always transfers at its own declared width.
// - Six clock blocks; block zero is the reference, others programmable.
// - A clock block may take its clock from an external 1-bit pin.
// - Input strobe qualifies sampling; output strobe marks driven data.
// - After reset the port uses clock block zero.
// - Pin events are flagged directly to the owning tile.
module tio_port
  import tio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  input wire logic input_strobe,
  output logic output_strobe,
  output logic port_event
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [5:0] tio_wbits(input logic [2:0] code);
    case (code)
      TIO_W1: tio_wbits = 6'd1;
      TIO_W4: tio_wbits = 6'd4;
      TIO_W8: tio_wbits = 6'd8;
      TIO_W16: tio_wbits = 6'd16;
      default: tio_wbits = 6'd32;
    endcase
  endfunction

  function automatic logic [31:0] tio_wmask(input logic [2:0] code);
    logic [5:0] w;
    w = tio_wbits(code);
    tio_wmask = (w == 6'd32) ? 32'hFFFFFFFF : ((32'h00000001 << w) - 32'h00000001);
  endfunction

  function automatic logic [5:0] tio_nslices(input logic [2:0] code);
    case (code)
      TIO_W1: tio_nslices = 6'd32;
      TIO_W4: tio_nslices = 6'd8;
      TIO_W8: tio_nslices = 6'd4;
      TIO_W16: tio_nslices = 6'd2;
      default: tio_nslices = 6'd1;
    endcase
  endfunction

  // Clock block index of an address, 7 when not a clock block register
  function automatic logic [2:0] tio_cb_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - TIO_OFF_CB0;
    if (a >= TIO_OFF_CB0 && d[11:2] < 10'd6 && d[1:0] == 2'b00)
      tio_cb_idx = d[4:2];
    else
      tio_cb_idx = 3'h7;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  tio_ctrl_type ctrl_r, ctrl_nxt;
  tio_cb_type cb_r [1:TIO_NCB-1];
  tio_cb_type cb_nxt [1:TIO_NCB-1];
  tio_state_type st_r, st_nxt;
  logic [31:0] cond_r, cond_nxt;
  logic [15:0] time_r, time_nxt;
  logic [1:0] nar_r, nar_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] ts_r, ts_nxt;
  logic [31:0] xfer_r, xfer_nxt;
  logic [31:0] sh_r, sh_nxt;
  logic [5:0] slc_r, slc_nxt;
  logic pend_r, pend_nxt;
  logic evt_r, evt_nxt;
  logic [31:0] pval_r, pval_nxt;
  logic ostb_r, ostb_nxt;
  logic [31:0] pout_r, pout_nxt;
  logic [31:0] poe_r, poe_nxt;
  logic [31:0] pin_s1_r, pin_s2_r;
  logic stb_s1_r, stb_s2_r;
  logic ext_tgl_r, ext_tgl_nxt;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic ext_tick;
  logic [TIO_NCB-1:0] tick;
  logic ptick;
  logic wr_take, rd_take, setup;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [5:0] wbits;
  logic [31:0] wmask;
  logic [31:0] slice_in;
  logic cond_hit, strobe_ok, go_ok, last;
  logic [31:0] sh_in;
  logic [31:0] link_mask;

  // ****************************************
  // External clock domain
  // ****************************************
  always_comb
  begin
    ext_tgl_nxt = ~ext_tgl_r;
  end

  always_ff @(posedge ext_clk or negedge presetn)
  begin
    if (!presetn)
      ext_tgl_r <= 1'b0;
    else
      ext_tgl_r <= ext_tgl_nxt;
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 32'h00000000;
      pin_s2_r <= 32'h00000000;
      stb_s1_r <= 1'b0;
      stb_s2_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      stb_s1_r <= input_strobe;
      stb_s2_r <= stb_s1_r;
      ext_s1_r <= ext_tgl_r;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign ext_tick = ext_s2_r ^ ext_s3_r;

  // ****************************************
  // Clock blocks
  // ****************************************
  assign tick[0] = 1'b1;

  genvar gi;
  generate
    for (gi = 1; gi < TIO_NCB; gi++)
    begin : g_cb
      logic [15:0] cbc_r, cbc_nxt;
      logic src, tk;
      always_comb
      begin
        src = cb_r[gi].ext_src ? ext_tick : 1'b1;
        tk = 1'b0;
        cbc_nxt = cbc_r;
        if (src)
        begin
          if (cbc_r >= cb_r[gi].div)
          begin
            cbc_nxt = 16'h0000;
            tk = 1'b1;
          end
          else
            cbc_nxt = cbc_r + 16'h0001;
        end
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          cbc_r <= 16'h0000;
        else
          cbc_r <= cbc_nxt;
      end
      assign tick[gi] = tk;
    end
  endgenerate

  assign ptick = (ctrl_r.clk_sel < 3'(TIO_NCB)) ? tick[ctrl_r.clk_sel] : 1'b0;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup = psel & ~penable;
  assign wr_take = psel & penable & pready_r & pwrite;
  assign rd_take = psel & penable & pready_r & ~pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      TIO_OFF_CTRL: rd_val = 32'(ctrl_r);
      TIO_OFF_DATA: rd_val = xfer_r;
      TIO_OFF_COND: rd_val = cond_r;
      TIO_OFF_TIME: rd_val = {16'h0000, time_r};
      TIO_OFF_COUNT: rd_val = {16'h0000, cnt_r};
      TIO_OFF_TSTAMP: rd_val = {16'h0000, ts_r};
      TIO_OFF_STATUS: rd_val = {28'h0000000, pend_r, evt_r, st_r};
      TIO_OFF_NARROW: rd_val = {29'h00000000, pin_s2_r[0], nar_r};
      default:
      begin
        if (tio_cb_idx(paddr) == 3'h0)
          rd_val = {15'h0000, TIO_DIV_RESET, 1'b0};
        else if (tio_cb_idx(paddr) < 3'h6)
          rd_val = {15'h0000, cb_r[tio_cb_idx(paddr)]};
        else
          rd_hit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    pready_nxt = setup;
    prdata_nxt = setup ? rd_val : prdata_r;
    pslverr_nxt = setup & ~rd_hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    cond_nxt = cond_r;
    time_nxt = time_r;
    nar_nxt = nar_r;
    for (int i = 1; i < TIO_NCB; i++)
      cb_nxt[i] = cb_r[i];
    if (wr_take)
    begin
      case (paddr)
        TIO_OFF_CTRL: ctrl_nxt = pwdata[TIO_CTRL_W-1:0];
        TIO_OFF_COND: cond_nxt = pwdata;
        TIO_OFF_TIME: time_nxt = pwdata[15:0];
        TIO_OFF_NARROW: nar_nxt = pwdata[1:0];
        default:
        begin
          for (int i = 1; i < TIO_NCB; i++)
            if (tio_cb_idx(paddr) == 3'(i))
              cb_nxt[i] = pwdata[16:0];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= '0;
      ctrl_r.clk_sel <= TIO_CB_RESET;
      cond_r <= 32'h00000000;
      time_r <= 16'h0000;
      nar_r <= 2'h0;
      for (int i = 1; i < TIO_NCB; i++)
        cb_r[i] <= {TIO_DIV_RESET, 1'b0};
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cond_r <= cond_nxt;
      time_r <= time_nxt;
      nar_r <= nar_nxt;
      for (int i = 1; i < TIO_NCB; i++)
        cb_r[i] <= cb_nxt[i];
    end
  end

  // ****************************************
  // Port engine
  // ****************************************
  assign wbits = tio_wbits(ctrl_r.width);
  assign wmask = tio_wmask(ctrl_r.width);
  assign slice_in = pin_s2_r & wmask;
  assign cond_hit = ((slice_in == (cond_r & wmask)) ^ ctrl_r.cond_ne);
  assign strobe_ok = ~ctrl_r.strobe_en | stb_s2_r;
  assign sh_in = (sh_r >> wbits) | (slice_in << (6'd32 - wbits));
  assign link_mask = ctrl_r.link_en ? TIO_LINK_MASK : 32'h00000000;

  always_comb
  begin
    go_ok = ~ctrl_r.timed_en | (cnt_r == time_r);
    if (!ctrl_r.dir_out)
      go_ok = go_ok & strobe_ok & (~ctrl_r.cond_en | cond_hit);
  end

  assign last = (slc_r == 6'd1);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ts_nxt = ts_r;
    xfer_nxt = xfer_r;
    sh_nxt = sh_r;
    slc_nxt = slc_r;
    pend_nxt = pend_r;
    evt_nxt = evt_r;
    pval_nxt = pval_r;
    ostb_nxt = 1'b0;
    if (rd_take && paddr == TIO_OFF_DATA)
      evt_nxt = 1'b0;
    if (wr_take && paddr == TIO_OFF_DATA)
    begin
      xfer_nxt = pwdata;
      pend_nxt = 1'b1;
    end
    if (ptick)
      cnt_nxt = cnt_r + 16'h0001;
    if (!ctrl_r.enable)
      st_nxt = TIO_ST_IDLE;
    else if (ptick)
    begin
      case (st_r)
        TIO_ST_IDLE:
        begin
          slc_nxt = tio_nslices(ctrl_r.width);
          if (!ctrl_r.dir_out)
            st_nxt = TIO_ST_WAIT;
          else if (pend_r)
          begin
            sh_nxt = xfer_r;
            pend_nxt = wr_take && paddr == TIO_OFF_DATA;
            st_nxt = TIO_ST_WAIT;
          end
        end
        TIO_ST_WAIT, TIO_ST_SHIFT:
        begin
          if (st_r == TIO_ST_SHIFT ? (ctrl_r.dir_out | strobe_ok) : go_ok)
          begin
            slc_nxt = slc_r - 6'd1;
            st_nxt = TIO_ST_SHIFT;
            if (ctrl_r.dir_out)
            begin
              pval_nxt = sh_r & wmask;
              sh_nxt = sh_r >> wbits;
              ostb_nxt = ctrl_r.strobe_en;
            end
            else
              sh_nxt = sh_in;
            if (last)
            begin
              ts_nxt = cnt_r;
              st_nxt = TIO_ST_IDLE;
              if (!ctrl_r.dir_out)
              begin
                xfer_nxt = sh_in;
                evt_nxt = 1'b1;
              end
            end
          end
        end
        default: st_nxt = TIO_ST_IDLE;
      endcase
    end
  end

  // Pin ownership: link first, then narrow port, then wide port
  always_comb
  begin
    poe_nxt = (ctrl_r.enable & ctrl_r.dir_out) ? wmask : 32'h00000000;
    pout_nxt = pval_r;
    if (ctrl_r.narrow_en)
    begin
      poe_nxt[0] = nar_r[1];
      pout_nxt[0] = nar_r[0];
    end
    poe_nxt = poe_nxt & ~link_mask;
    pout_nxt = pout_nxt & ~link_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= TIO_ST_IDLE;
      cnt_r <= 16'h0000;
      ts_r <= 16'h0000;
      xfer_r <= 32'h00000000;
      sh_r <= 32'h00000000;
      slc_r <= 6'd0;
      pend_r <= 1'b0;
      evt_r <= 1'b0;
      pval_r <= 32'h00000000;
      ostb_r <= 1'b0;
      pout_r <= 32'h00000000;
      poe_r <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ts_r <= ts_nxt;
      xfer_r <= xfer_nxt;
      sh_r <= sh_nxt;
      slc_r <= slc_nxt;
      pend_r <= pend_nxt;
      evt_r <= evt_nxt;
      pval_r <= pval_nxt;
      ostb_r <= ostb_nxt;
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign output_strobe = ostb_r;
  assign port_event = evt_r;

endmodule

// ### tio_props.sv
// Checker for the timed I/O port bus and pin behaviour
`timescale 1ns/10ps
module tio_props
  import tio_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic port_event
);
  logic link_r;
  logic link_nxt;
  logic keep_ev;
  // ****
  // Link enable as last written
  // ****
  always_comb
  begin
    link_nxt = link_r;
    if (psel && penable && pready && pwrite && paddr == TIO_OFF_CTRL)
    begin
      link_nxt = pwdata[12];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_r <= 1'b0;
    end
    else
    begin
      link_r <= link_nxt;
    end
  end
  assign keep_ev = !(psel && penable && (paddr == TIO_OFF_DATA && !pwrite
    || paddr == TIO_OFF_CTRL && pwrite));
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> s_answer)
    else $error("pready not one cycle after setup");
  a_ready_quiet: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside answer");
  a_mapped_no_err: assert property (psel && !penable && paddr <= 12'h034
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("pslverr on mapped address");
  a_link_pins_off: assert property (link_r && $past(link_r, 3)
    |-> ((pin_oe | pin_out) & TIO_LINK_MASK) == 32'h0)
    else $error("link pins still used by port");
  a_dir_one_way: assert property (pin_oe[31] |-> &pin_oe[30:10])
    else $error("mixed directions on port");
  a_event_held: assert property (port_event && keep_ev |=> port_event)
    else $error("event dropped before data read");
  a_reset_quiet: assert property (disable iff (1'b0) !presetn
    |-> pin_oe == 32'h0 && pin_out == 32'h0 && !port_event && !pready)
    else $error("outputs active in reset");
endmodule

// ### tio_pins_model.sv
// Model of the hardware wired to the port pins
`timescale 1ns/10ps
module tio_pins_model
  import tio_pkg::*;
(
  input wire logic [31:0] drive_val,
  input wire logic drive_en,
  input wire logic strobe_req,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pin_in,
  output logic input_strobe
);
  // Our drive wins, else device drive, else pull-down
  always_comb
  begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & (drive_en ? drive_val : 32'h0));
    input_strobe = strobe_req;
  end
endmodule

// ### testbench.sv
// Top-level bench for the timed I/O port
`timescale 1ns/10ps
module testbench
  import tio_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ext_clk = 1'b0;
  logic [31:0] drive_val = 32'h0;
  logic drive_en = 1'b0;
  logic strobe_req = 1'b0;
  logic [31:0] prdata, pin_in, pin_out, pin_oe, rd, c;
  logic pready, pslverr, input_strobe, output_strobe, port_event, err;
  int errors = 0;
  int cmp_count = 0;
  int n;
  always #4 pclk = ~pclk;
  initial
  begin
    #3;
    forever #80 ext_clk = ~ext_clk;
  end
  tio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk(ext_clk), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .input_strobe(input_strobe), .output_strobe(output_strobe),
    .port_event(port_event));
  tio_pins_model pins_u (.drive_val(drive_val), .drive_en(drive_en),
    .strobe_req(strobe_req), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .input_strobe(input_strobe));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t bus answer missing", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_event;
    n = 0;
    while (port_event !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (port_event !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t no port event", $time);
    end
  endtask
  task automatic t_reset;
    apb(0, TIO_OFF_CTRL, 0);
    check(rd, 32'h0, "ctrl reset");
    apb(1, TIO_OFF_CB0, 32'h0000FFFF);
    apb(0, TIO_OFF_CB0, 0);
    check(rd, 32'h0, "block zero fixed");
    apb(1, TIO_OFF_CB0 + 12'h004, 32'h0000000A);
    apb(0, TIO_OFF_CB0 + 12'h004, 0);
    check(rd, 32'h0000000A, "block one");
    apb(0, 12'hFFC, 0);
    check({31'h0, err}, 32'h1, "unmapped");
    apb(0, TIO_OFF_COUNT, 0);
    c = rd;
    apb(0, TIO_OFF_COUNT, 0);
    check({16'h0, rd[15:0] - c[15:0]}, 32'h3, "count step");
    $display("test reset done");
  endtask
  task automatic t_out;
    int p;
    for (int i = 0; i < 2; i++)
    begin
      apb(1, TIO_OFF_CTRL, i ? 32'h0000080B : 32'h00000813);
      apb(1, TIO_OFF_DATA, 32'h44332211);
      p = 0;
      repeat (40)
      begin
        @(posedge pclk);
        p += (output_strobe === 1'b1);
      end
      check(p, i ? 4 : 1, "strobes");
      check(pin_out & (i ? 32'hFF : 32'hFFFFFFFF), i ? 32'h44 : 32'h44332211, "out");
      check(pin_oe & 32'hFF, 32'hFF, "oe");
    end
    apb(1, TIO_OFF_NARROW, 32'h3);
    apb(1, TIO_OFF_CTRL, 32'h00003013);
    apb(1, TIO_OFF_DATA, 32'hFFFFFFFE);
    repeat (10) @(posedge pclk);
    check(pin_oe, ~TIO_LINK_MASK, "link oe");
    check(pin_out, 32'hFFFFFC01, "narrow pin");
    apb(1, TIO_OFF_CTRL, 0);
    $display("test output done");
  endtask
  task automatic t_in_cond;
    drive_en <= 1'b1;
    drive_val <= 32'h12345678;
    apb(1, TIO_OFF_COND, 32'h0000BEEF);
    apb(1, TIO_OFF_CTRL, 32'h00000111);
    repeat (20) @(posedge pclk);
    check({31'h0, port_event}, 0, "held by cond");
    drive_val <= 32'h0000BEEF;
    wait_event();
    check({31'h0, port_event}, 1, "event");
    drive_val <= 32'h0000CAFE;
    apb(0, TIO_OFF_TSTAMP, 0);
    c = rd;
    apb(0, TIO_OFF_COUNT, 0);
    check({31'h0, rd[15:0] - c[15:0] < 16'd40}, 1, "stamp");
    check({31'h0, port_event}, 1, "event stands");
    apb(0, TIO_OFF_DATA, 0);
    check(rd, 32'h0000BEEF, "data in");
    check({31'h0, port_event}, 0, "event cleared");
    apb(1, TIO_OFF_CTRL, 0);
    $display("test condition done");
  endtask
  task automatic t_in_strobe;
    drive_val <= 32'hA5A5A5A5;
    apb(1, TIO_OFF_CTRL, 32'h00000811);
    repeat (20) @(posedge pclk);
    check({31'h0, port_event}, 0, "no strobe");
    strobe_req <= 1'b1;
    wait_event();
    apb(0, TIO_OFF_DATA, 0);
    check(rd, 32'hA5A5A5A5, "strobed data");
    strobe_req <= 1'b0;
    apb(1, TIO_OFF_CTRL, 0);
    $display("test strobe done");
  endtask
  task automatic t_ext;
    apb(1, TIO_OFF_CB0 + 12'h004, 32'h00000001);
    apb(1, TIO_OFF_CTRL, 32'h00000020);
    apb(0, TIO_OFF_COUNT, 0);
    c = rd;
    repeat (400) @(posedge pclk);
    apb(0, TIO_OFF_COUNT, 0);
    n = rd[15:0] - c[15:0];
    check({31'h0, n == 20 || n == 21}, 1, "ext ticks");
    apb(1, TIO_OFF_CTRL, 32'h00000033);
    apb(1, TIO_OFF_DATA, 32'h0000600D);
    repeat (100) @(posedge pclk);
    check(pin_out, 32'h0000600D, "ext out");
    $display("test ext clock done");
  endtask
  task automatic t_timed;
    apb(1, TIO_OFF_CTRL, 32'h0000040E);
    apb(0, TIO_OFF_COUNT, 0);
    c = rd;
    apb(1, TIO_OFF_TIME, {16'h0, c[15:0] + 16'd60});
    apb(1, TIO_OFF_CTRL, 32'h0000040F);
    apb(1, TIO_OFF_DATA, 32'h87654321);
    repeat (20) @(posedge pclk);
    check(pin_out, 32'h0000600D, "held for time");
    check(pin_oe, 32'h0000FFFF, "oe 16");
    repeat (40) @(posedge pclk);
    check(pin_out, 32'h00008765, "timed data");
    apb(0, TIO_OFF_TSTAMP, 0);
    check({31'h0, rd[15:0] - c[15:0] - 16'd60 < 16'd2}, 1, "timed stamp");
    apb(1, TIO_OFF_CTRL, 0);
    $display("test timed done");
  endtask
  task automatic t_in_ne;
    drive_val <= 32'h0000000F;
    apb(1, TIO_OFF_COND, 32'h0000000F);
    apb(1, TIO_OFF_CTRL, 32'h00000305);
    apb(0, TIO_OFF_DATA, 0);
    repeat (20) @(posedge pclk);
    check({31'h0, port_event}, 0, "held by equal");
    drive_val <= 32'h00000009;
    wait_event();
    apb(0, TIO_OFF_DATA, 0);
    check(rd, 32'h99999999, "nibble word");
    apb(1, TIO_OFF_CTRL, 0);
    $display("test not equal done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    results();
  end
  initial
  begin
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_out();
    t_in_cond();
    t_in_strobe();
    t_ext();
    t_timed();
    t_in_ne();
    results();
  end
endmodule
bind tio_port tio_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
  .port_event(port_event));
